// >>> hw/bsm_pkg.sv
package bsm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATE    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_S2B      = 8'h10;
  localparam logic [7:0] ADDR_B2S      = 8'h14;
  localparam logic [7:0] ADDR_CLK_WR   = 8'h18;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MEASURE  = 0;  // sensor_measure_enable
  localparam int CTRL_BKSENSOR = 1;  // backup_sensor_enable
  localparam int CTRL_CLRSTAMP = 2;  // clear_stamp_bit
  localparam int CTRL_IOOFF    = 3;  // backup io disable
  localparam int CTRL_BOSEL    = 4;  // brownout level select, 3 bits
  localparam int CTRL_W        = 7;

  // ----------------------------------------------------------------
  // interrupt status / mask bit positions
  // ----------------------------------------------------------------
  localparam int IRQ_TOTAL    = 0;  // total_power_loss_flag
  localparam int IRQ_BROWNOUT = 1;  // brownout_flag
  localparam int IRQ_BATUP    = 2;  // battery_upper_warning
  localparam int IRQ_BATLO    = 3;  // battery_lower_warning
  localparam int IRQ_TOBAT    = 4;  // supply to battery switch
  localparam int IRQ_TOMAIN   = 5;  // battery to supply switch
  localparam int IRQ_W        = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [IRQ_W-1:0]  MASK_RST = 6'h00;
  localparam int                BO_LEVELS = 6;

  // power mode states
  typedef enum logic [2:0] {
    ST_MAIN    = 3'b001,
    ST_BACKUP  = 3'b010,
    ST_MEASURE = 3'b100
  } bsm_state_t;

endpackage : bsm_pkg

// >>> hw/bsm_sync.sv
`timescale 1ns/1ns
`default_nettype none

module bsm_sync #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } bsm_sync_t;

  bsm_sync_t q;
  bsm_sync_t d;

  if (WIDTH < 1) begin : g_badWidth
    $error("bsm_sync: WIDTH must be at least 1");
  end

  // ----------------------------------------------------------------
  // two stage capture, two flops per bit
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        d.meta[gi]   = asyncIn[gi];
        d.stable[gi] = q.meta[gi];  // first stage feeds only this
      end
    end
  endgenerate

  // registered copy, frozen while clock enable is low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign syncOut = q.stable;

endmodule : bsm_sync

`default_nettype wire

// >>> hw/bsm_backup_monitor.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Enter battery mode only if below battery-hysteresis and below trip level.
// - Leave battery mode when above battery+hysteresis or above trip+hysteresis.
// - Host serial interface is disabled while in battery mode; the APB slave still accepts transfers.
// - Timekeeping keeps running; other pins stay on unless disabled for backup.
// - First supply-to-battery switch after a clear copies calendar time into the first stamp.
// - Keep earliest supply-to-battery stamp; overwrite battery-to-supply with latest.
// - First stamp holds until host writes one to clear-stamp; then stores clear.
// - Set total power loss flag after power-up from loss of both supplies.
// - Six selectable brownout levels for the main supply monitor.
// - Brownout flag set whenever supply is below selected brownout level.
// - Brownout leaves the host interface on; only switchover disables it.
// - Battery between thresholds sets only the upper warning flag.
// - Battery below lower threshold sets both warning flags.
// - No battery level measurement in battery mode; warnings stay unchanged.
// - Temperature sensing runs in battery mode only with backup sensor enable.
// - After total loss, counters stay stopped until host writes clock register.

module bsm_backup_monitor #(
  parameter int NUM_BO  = bsm_pkg::BO_LEVELS,
  parameter int STAMP_W = 32
) (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               clkEn,
  // comparator indications, asynchronous
  input  wire logic               vddBelowBatHys,
  input  wire logic               vddBelowTrip,
  input  wire logic               vddAboveBatHys,
  input  wire logic               vddAboveTripHys,
  input  wire logic [NUM_BO-1:0]  vddBelowBrownout,
  input  wire logic               batBelowUpper,
  input  wire logic               batBelowLower,
  // power-on indication and sensing handshake
  input  wire logic               allSupplyLost,
  input  wire logic               measureDone,
  input  wire logic [STAMP_W-1:0] calendarNow,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // block outputs
  output logic                    backupMode,
  output logic                    hostIfEnable,
  output logic                    ioEnable,
  output logic                    timekeepRun,
  output logic                    sensorRun,
  output logic                    batteryMeasure,
  output logic                    irq
);

  localparam int SYNC_W = NUM_BO + 6;

  typedef struct packed {
    bsm_pkg::bsm_state_t           st;
    logic [bsm_pkg::CTRL_W-1:0]    ctrl;
    logic [bsm_pkg::IRQ_W-1:0]     irqStat;
    logic [bsm_pkg::IRQ_W-1:0]     irqMask;
    logic [STAMP_W-1:0]            s2b;
    logic [STAMP_W-1:0]            b2s;
    logic                          stampValid;
    logic                          running;
    logic                          strapDone;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
    logic                          irq;
    logic                          hostIf;
    logic                          ioEn;
    logic                          sensorRun;
    logic                          measReq;
    logic                          bakMode;
  } bsm_regs_t;

  bsm_regs_t q;
  bsm_regs_t n;

  if (NUM_BO != bsm_pkg::BO_LEVELS || STAMP_W < 1 || STAMP_W > 32) begin : g_badParam
    $error("bsm: NUM_BO must be 6 and STAMP_W 1..32");
  end

  // ----------------------------------------------------------------
  // comparator synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] syncVec;
  logic              belowBat;
  logic              belowTrip;
  logic              aboveBat;
  logic              aboveTrip;
  logic [NUM_BO-1:0] belowBo;
  logic              batUpS;
  logic              batLoS;

  // every analog indication crosses two flops first
  bsm_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .asyncIn ({batBelowLower, batBelowUpper, vddBelowBrownout, vddAboveTripHys,
               vddAboveBatHys, vddBelowTrip, vddBelowBatHys}),
    .syncOut (syncVec)
  );

  assign belowBat  = syncVec[0];
  assign belowTrip = syncVec[1];
  assign aboveBat  = syncVec[2];
  assign aboveTrip = syncVec[3];
  assign belowBo   = syncVec[4 +: NUM_BO];
  assign batUpS    = syncVec[4 + NUM_BO];
  assign batLoS    = syncVec[5 + NUM_BO];

  // ----------------------------------------------------------------
  // decoded conditions
  // ----------------------------------------------------------------
  logic                        enterBak;
  logic                        leaveBak;
  logic                        commit;
  logic                        wrCommit;
  logic                        boLow;
  logic [2:0]                  boSel;
  logic [bsm_pkg::CTRL_W-1:0]  wrCtrl;

  assign enterBak = (q.st != bsm_pkg::ST_BACKUP) && belowBat && belowTrip;
  assign leaveBak = (q.st == bsm_pkg::ST_BACKUP) && (aboveBat || aboveTrip);
  assign commit   = psel && penable && q.pready;
  assign wrCommit = commit && pwrite;
  assign boSel    = q.ctrl[bsm_pkg::CTRL_BOSEL +: 3];
  assign boLow    = (boSel < 3'(NUM_BO)) && belowBo[boSel];
  assign wrCtrl   = pwdata[bsm_pkg::CTRL_W-1:0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [bsm_pkg::IRQ_W-1:0] evt;
    logic [bsm_pkg::IRQ_W-1:0] w1c;
    logic                      stampClr;
    evt      = '0;
    w1c      = '0;
    n        = q;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    stampClr = q.ctrl[bsm_pkg::CTRL_CLRSTAMP];
    n.ctrl[bsm_pkg::CTRL_CLRSTAMP] = 1'b0;  // self clearing

    // power mode sequencing
    case (q.st)
      bsm_pkg::ST_MAIN: begin
        if (enterBak) begin
          n.st = bsm_pkg::ST_BACKUP;
        end else if (q.ctrl[bsm_pkg::CTRL_MEASURE]) begin
          n.st = bsm_pkg::ST_MEASURE;
        end
      end
      bsm_pkg::ST_MEASURE: begin
        if (enterBak) begin
          n.st = bsm_pkg::ST_BACKUP;  // measurement dropped
        end else if (measureDone) begin
          evt[bsm_pkg::IRQ_BATUP] = batUpS || batLoS;
          evt[bsm_pkg::IRQ_BATLO] = batLoS;
          n.ctrl[bsm_pkg::CTRL_MEASURE] = 1'b0;
          n.st = bsm_pkg::ST_MAIN;
        end
      end
      bsm_pkg::ST_BACKUP: begin
        if (leaveBak) begin
          n.st = bsm_pkg::ST_MAIN;
        end
      end
      default: begin
        n.st = bsm_pkg::ST_MAIN;
      end
    endcase

    // switchover time stamps
    if (stampClr) begin
      n.s2b        = '0;
      n.b2s        = '0;
      n.stampValid = 1'b0;
    end
    if (enterBak && (!q.stampValid || stampClr)) begin
      n.s2b        = calendarNow;  // earliest kept
      n.stampValid = 1'b1;
    end
    if (leaveBak) begin
      n.b2s = calendarNow;  // latest kept
    end
    evt[bsm_pkg::IRQ_TOBAT]  = enterBak;
    evt[bsm_pkg::IRQ_TOMAIN] = leaveBak;

    // brownout monitor, independent of host interface
    evt[bsm_pkg::IRQ_BROWNOUT] = boLow;

    // power-on check caught once after reset release
    if (!q.strapDone) begin
      n.strapDone = 1'b1;
      n.running   = !allSupplyLost;
      evt[bsm_pkg::IRQ_TOTAL] = allSupplyLost;
    end

    // apb access phase
    if (psel && penable && !q.pready) begin
      n.pready = 1'b1;
      n.prdata = '0;
      if (paddr == bsm_pkg::ADDR_CTRL) begin
        n.prdata[bsm_pkg::CTRL_W-1:0] = q.ctrl;
      end else if (paddr == bsm_pkg::ADDR_STATE) begin
        n.prdata[4:0] = {q.stampValid, q.measReq, q.running, q.hostIf, q.bakMode};
      end else if (paddr == bsm_pkg::ADDR_IRQ_STAT) begin
        n.prdata[bsm_pkg::IRQ_W-1:0] = q.irqStat;
      end else if (paddr == bsm_pkg::ADDR_IRQ_MASK) begin
        n.prdata[bsm_pkg::IRQ_W-1:0] = q.irqMask;
      end else if (paddr == bsm_pkg::ADDR_S2B) begin
        n.prdata[STAMP_W-1:0] = q.s2b;
      end else if (paddr == bsm_pkg::ADDR_B2S) begin
        n.prdata[STAMP_W-1:0] = q.b2s;
      end else if (paddr == bsm_pkg::ADDR_CLK_WR) begin
        n.prdata = '0;
      end else begin
        n.pslverr = 1'b1;
      end
    end

    // writes land on the edge where pready is seen high
    if (wrCommit) begin
      if (paddr == bsm_pkg::ADDR_CTRL) begin
        n.ctrl[bsm_pkg::CTRL_MEASURE]  = wrCtrl[bsm_pkg::CTRL_MEASURE]
          || n.ctrl[bsm_pkg::CTRL_MEASURE];
        n.ctrl[bsm_pkg::CTRL_BKSENSOR] = wrCtrl[bsm_pkg::CTRL_BKSENSOR];
        n.ctrl[bsm_pkg::CTRL_CLRSTAMP] = wrCtrl[bsm_pkg::CTRL_CLRSTAMP];
        n.ctrl[bsm_pkg::CTRL_IOOFF]    = wrCtrl[bsm_pkg::CTRL_IOOFF];
        if (wrCtrl[bsm_pkg::CTRL_BOSEL +: 3] < 3'(NUM_BO)) begin
          n.ctrl[bsm_pkg::CTRL_BOSEL +: 3] = wrCtrl[bsm_pkg::CTRL_BOSEL +: 3];
        end
      end else if (paddr == bsm_pkg::ADDR_IRQ_STAT) begin
        w1c = pwdata[bsm_pkg::IRQ_W-1:0];
      end else if (paddr == bsm_pkg::ADDR_IRQ_MASK) begin
        n.irqMask = pwdata[bsm_pkg::IRQ_W-1:0];
      end else if (paddr == bsm_pkg::ADDR_CLK_WR) begin
        n.running = 1'b1;
      end
    end

    // sticky events, a new event beats a clear
    n.irqStat = (q.irqStat & ~w1c) | evt;

    // outputs follow the next mode
    n.hostIf    = (n.st != bsm_pkg::ST_BACKUP);
    n.ioEn      = !((n.st == bsm_pkg::ST_BACKUP) && n.ctrl[bsm_pkg::CTRL_IOOFF]);
    n.sensorRun = (n.st != bsm_pkg::ST_BACKUP) || n.ctrl[bsm_pkg::CTRL_BKSENSOR];
    n.measReq   = (n.st == bsm_pkg::ST_MEASURE);
    n.bakMode   = (n.st == bsm_pkg::ST_BACKUP);
    n.irq       = |(n.irqStat & n.irqMask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q         <= '0;
      q.st      <= bsm_pkg::ST_MAIN;
      q.ctrl    <= bsm_pkg::CTRL_RST;
      q.irqMask <= bsm_pkg::MASK_RST;
      q.hostIf  <= 1'b1;
      q.ioEn    <= 1'b1;
      q.sensorRun <= 1'b1;
    end else if (clkEn) begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata         = q.prdata;
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;
  assign backupMode     = q.bakMode;
  assign hostIfEnable   = q.hostIf;
  assign ioEnable       = q.ioEn;
  assign timekeepRun    = q.running;  // counters run in every mode
  assign sensorRun      = q.sensorRun;
  assign batteryMeasure = q.measReq;
  assign irq            = q.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || !clkEn);

  sequence s_clrWrite;
    wrCommit && paddr == bsm_pkg::ADDR_CTRL && pwdata[bsm_pkg::CTRL_CLRSTAMP];
  endsequence
  sequence s_clrDone;
    !q.ctrl[bsm_pkg::CTRL_CLRSTAMP] && (q.stampValid == $past(enterBak));
  endsequence

  property p_enter;
    q.st == bsm_pkg::ST_MAIN && belowBat && belowTrip |=> backupMode;
  endproperty
  a_enter: assert property (p_enter) else $error("no switch to battery");

  property p_noEnter;
    !backupMode && !(belowBat && belowTrip) |=> !backupMode;
  endproperty
  a_noEnter: assert property (p_noEnter) else $error("early battery switch");

  property p_leave;
    backupMode && (aboveBat || aboveTrip) |=> !backupMode && q.irqStat[bsm_pkg::IRQ_TOMAIN];
  endproperty
  a_leave: assert property (p_leave) else $error("no return to supply");

  property p_hostOff;
    backupMode |-> !hostIfEnable && !batteryMeasure;
  endproperty
  a_hostOff: assert property (p_hostOff) else $error("host on in battery");

  property p_s2b;
    enterBak && !q.stampValid |=> q.s2b == $past(calendarNow) && q.stampValid;
  endproperty
  a_s2b: assert property (p_s2b) else $error("stamp not captured");

  property p_keep;
    q.stampValid && !q.ctrl[bsm_pkg::CTRL_CLRSTAMP] |=> $stable(q.s2b);
  endproperty
  a_keep: assert property (p_keep) else $error("earliest stamp lost");

  property p_clear;
    s_clrWrite ##1 1'b1 |=> s_clrDone;
  endproperty
  a_clear: assert property (p_clear) else $error("stamp not cleared");

  property p_brown;
    boLow && q.strapDone |=> q.irqStat[bsm_pkg::IRQ_BROWNOUT] && hostIfEnable == !backupMode;
  endproperty
  a_brown: assert property (p_brown) else $error("brownout missed");

  property p_lower;
    q.st == bsm_pkg::ST_MEASURE && measureDone && !enterBak && batLoS
      |=> q.irqStat[bsm_pkg::IRQ_BATUP] && q.irqStat[bsm_pkg::IRQ_BATLO];
  endproperty
  a_lower: assert property (p_lower) else $error("low battery flags");

  property p_sensor;
    backupMode && !q.ctrl[bsm_pkg::CTRL_BKSENSOR] |-> !sensorRun;
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor on in battery");

  property p_hold;
    q.strapDone && !timekeepRun && !(wrCommit && paddr == bsm_pkg::ADDR_CLK_WR)
      |=> !timekeepRun;
  endproperty
  a_hold: assert property (p_hold) else $error("counters started early");

endmodule : bsm_backup_monitor

`default_nettype wire

// >>> verif/bsm_supply_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// supply comparator bank, levels in millivolts
// ----------------------------------------------------------------
module bsm_supply_model #(
  parameter int BAT_HYS  = 50,
  parameter int TRIP     = 2200,
  parameter int TRIP_HYS = 30,
  parameter int BAT_NOM  = 3000,
  parameter int BO_TOP   = 3100,
  parameter int BO_STEP  = 100
) (
  input  wire logic [15:0] vddMv,
  input  wire logic [15:0] batMv,
  output logic             vddBelowBatHys,
  output logic             vddBelowTrip,
  output logic             vddAboveBatHys,
  output logic             vddAboveTripHys,
  output logic [5:0]       vddBelowBrownout,
  output logic             batBelowUpper,
  output logic             batBelowLower
);
  // comparators follow the analog levels at once
  always_comb begin
    vddBelowBatHys  = int'(vddMv) < int'(batMv) - BAT_HYS;
    vddBelowTrip    = int'(vddMv) < TRIP;
    vddAboveBatHys  = int'(vddMv) > int'(batMv) + BAT_HYS;
    vddAboveTripHys = int'(vddMv) > TRIP + TRIP_HYS;
    for (int k = 0; k < 6; k++) begin
      vddBelowBrownout[k] = int'(vddMv) < BO_TOP - k * BO_STEP;
    end
    batBelowUpper = int'(batMv) * 100 < BAT_NOM * 85;
    batBelowLower = int'(batMv) * 100 < BAT_NOM * 75;
  end
endmodule : bsm_supply_model
`default_nettype wire

// >>> verif/bsm_backup_monitor_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bsm_backup_monitor_tb;
  logic        clk_sys, reset, allSupplyLost, measureDone;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, cal;
  logic [15:0] vdd, bat;
  logic        bBat, bTrip, aBat, aTrip, bUp, bLo;
  logic [5:0]  bBo;
  logic        backupMode, hostIfEnable, ioEnable, timekeepRun;
  logic        sensorRun, batteryMeasure, irq;
  int          num_errors, comparisons;

  // ----------------------------------------------------------------
  // clock, design and comparator bank
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  bsm_supply_model bsm_supply_model_inst (.vddMv(vdd), .batMv(bat),
    .vddBelowBatHys(bBat), .vddBelowTrip(bTrip), .vddAboveBatHys(aBat),
    .vddAboveTripHys(aTrip), .vddBelowBrownout(bBo), .batBelowUpper(bUp),
    .batBelowLower(bLo));
  bsm_backup_monitor bsm_backup_monitor_inst (.clk_sys(clk_sys), .reset(reset),
    .clkEn(1'b1), .vddBelowBatHys(bBat), .vddBelowTrip(bTrip),
    .vddAboveBatHys(aBat), .vddAboveTripHys(aTrip), .vddBelowBrownout(bBo),
    .batBelowUpper(bUp), .batBelowLower(bLo), .allSupplyLost(allSupplyLost),
    .measureDone(measureDone), .calendarNow(cal), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .backupMode(backupMode), .hostIfEnable(hostIfEnable), .ioEnable(ioEnable),
    .timekeepRun(timekeepRun), .sensorRun(sensorRun),
    .batteryMeasure(batteryMeasure), .irq(irq));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);  // idle edge between transfers
    if (n >= 40) begin
      num_errors++;
      close_out();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(a, 1'b0, 32'h0, d, e);
  endtask : rd
  task automatic wait_hi(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 30) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 30) begin
      num_errors++;
      close_out();
    end
    @(posedge clk_sys);
  endtask : wait_hi
  task automatic supply(input int v, input int b);
    vdd <= 16'(v);
    bat <= 16'(b);
  endtask : supply
  task automatic measure();
    wait_hi(batteryMeasure, 1'b1);
    measureDone <= 1'b1;
    @(posedge clk_sys);
    measureDone <= 1'b0;
    hold(2);
  endtask : measure

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic        e;
    rd(bsm_pkg::ADDR_CTRL, d);
    chk(d, 32'h0);
    rd(bsm_pkg::ADDR_IRQ_MASK, d);
    chk(d, 32'h0);
    rd(bsm_pkg::ADDR_STATE, d);
    chk(d, 32'h2);
    rd(bsm_pkg::ADDR_IRQ_STAT, d);
    chk(d[0], 1'b1);
    hold(20);
    chk(timekeepRun, 1'b0);
    wr(bsm_pkg::ADDR_CLK_WR, 32'h5);
    hold(1);
    chk(timekeepRun, 1'b1);
    apb(8'h3c, 1'b0, 32'h0, d, e);
    chk(d, 32'h0);
    chk(32'(e), 32'h1);
  endtask : t_reset

  task automatic t_switch();
    logic [31:0] d;
    wr(bsm_pkg::ADDR_CTRL, 32'h0a);
    cal <= 32'h0000_1111;
    supply(2100, 2000);
    hold(8);
    chk(backupMode, 1'b0);
    supply(2900, 3000);
    hold(8);
    chk(backupMode, 1'b0);
    supply(1500, 3000);
    hold(2);
    chk(backupMode, 1'b0);
    wait_hi(backupMode, 1'b1);
    chk({hostIfEnable, timekeepRun, ioEnable, sensorRun}, 4'h5);
    cal <= 32'h0000_2222;
    supply(2220, 3000);
    hold(8);
    chk(backupMode, 1'b1);
    supply(2240, 3000);
    wait_hi(backupMode, 1'b0);
    chk({hostIfEnable, ioEnable}, 2'h3);
    wr(bsm_pkg::ADDR_CTRL, 32'h0);
    cal <= 32'h0000_3333;
    supply(1500, 3000);
    wait_hi(backupMode, 1'b1);
    chk({ioEnable, sensorRun}, 2'h2);
    wr(bsm_pkg::ADDR_CTRL, 32'h1);
    hold(8);
    chk(batteryMeasure, 1'b0);
    cal <= 32'h0000_4444;
    supply(2100, 2000);
    wait_hi(backupMode, 1'b0);
    measure();
    rd(bsm_pkg::ADDR_IRQ_STAT, d);
    chk(d[5:2], 4'hf);
    rd(bsm_pkg::ADDR_S2B, d);
    chk(d, 32'h0000_1111);
    rd(bsm_pkg::ADDR_B2S, d);
    chk(d, 32'h0000_4444);
    wr(bsm_pkg::ADDR_CTRL, 32'h4);
    hold(3);
    rd(bsm_pkg::ADDR_S2B, d);
    chk(d, 32'h0);
    supply(3300, 3000);
    hold(4);
    wr(bsm_pkg::ADDR_IRQ_STAT, 32'h3f);
  endtask : t_switch

  task automatic t_brownout();
    logic [31:0] d;
    wr(bsm_pkg::ADDR_IRQ_MASK, 32'h2);
    for (int k = 0; k < 6; k++) begin
      // pick the next lower level first, so the drop stays above it
      if (k < 5) begin
        wr(bsm_pkg::ADDR_CTRL, 32'(k + 1) << bsm_pkg::CTRL_BOSEL);
      end
      supply(3050 - 100 * k, 3000);
      hold(4);
      if (k < 5) begin
        rd(bsm_pkg::ADDR_IRQ_STAT, d);
        chk(d[1], 1'b0);
      end
      wr(bsm_pkg::ADDR_CTRL, 32'(k) << bsm_pkg::CTRL_BOSEL);
      hold(4);
      rd(bsm_pkg::ADDR_IRQ_STAT, d);
      chk({d[1], irq, hostIfEnable}, 3'h7);
      supply(3300, 3000);
      hold(4);
      wr(bsm_pkg::ADDR_IRQ_STAT, 32'h2);
      hold(2);
      rd(bsm_pkg::ADDR_IRQ_STAT, d);
      chk({d[1], irq}, 2'h0);
    end
  endtask : t_brownout

  task automatic t_battery();
    logic [31:0] d;
    supply(3300, 2400);
    hold(4);
    wr(bsm_pkg::ADDR_CTRL, 32'h1);
    measure();
    rd(bsm_pkg::ADDR_IRQ_STAT, d);
    chk(d[3:2], 2'h1);
  endtask : t_battery

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    allSupplyLost = 1'b1;
    measureDone = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cal = 32'h0;
    vdd = 16'd3300;
    bat = 16'd3000;
    num_errors = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    @(posedge clk_sys);
    allSupplyLost <= 1'b0;
    t_reset();
    t_switch();
    t_brownout();
    t_battery();
    close_out();
  end
endmodule : bsm_backup_monitor_tb
`default_nettype wire
